/* File: hw/cls_supervisor.sv */
// Purpose: cold load supervisor with AXI4-Lite registers
// Assumes: current magnitude and comparator inputs synchronous to clk
// Notes: the block only reports; protection elements act on cold_load_active
`timescale 1ns/1ps
`default_nettype none
module cls_supervisor #(
  parameter int TICK_CYCLES = cls_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire cls_pkg::cls_ins_t ins,
  input wire logic [cls_pkg::CW-1:0] load_current,
  output logic cold_load_active,
  input wire logic [cls_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cls_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = cls_pkg::CW;
  localparam int TW = cls_pkg::TW;
  localparam int AW = cls_pkg::AW;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
    $error("cls_supervisor: TICK_CYCLES out of range");
  end

  function automatic logic addr_mapped(input logic [AW-1:0] a);
    addr_mapped = (a == cls_pkg::ADDR_CTRL) || (a == cls_pkg::ADDR_LOADOFF) ||
      (a == cls_pkg::ADDR_SETTLE) || (a == cls_pkg::ADDR_MAXBLK) ||
      (a == cls_pkg::ADDR_INRUSH) || (a == cls_pkg::ADDR_STATUS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic cold_detect(input logic [1:0] mode, input logic brk_open,
                                       input logic uc);
    case (mode)
      cls_pkg::MODE_BRK: cold_detect = brk_open;
      cls_pkg::MODE_UC: cold_detect = uc;
      cls_pkg::MODE_AND: cold_detect = brk_open && uc;
      default: cold_detect = brk_open || uc;
    endcase
  endfunction

  cls_pkg::cls_cfg_t cfg;
  cls_pkg::cls_state_t state;
  cls_pkg::cls_state_t next_state;
  logic aw_got;
  logic w_got;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [15:0] presc;
  logic tick;
  logic cold;
  logic blocked;
  logic above_thr;
  logic below_drop;
  logic inrush;
  logic lo_done;
  logic st_done;
  logic mb_done;
  logic st_run;
  logic [CW+3:0] cur_scaled;
  logic [CW+3:0] thr_scaled;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cls_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr) ? cls_pkg::RESP_OKAY : cls_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; status ignores writes
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg.en <= cls_pkg::CTRL_EN_RST;
      cfg.mode <= cls_pkg::CTRL_MODE_RST;
      cfg.sw_block <= 1'b0;
      cfg.t_loadoff <= cls_pkg::LOADOFF_RST;
      cfg.t_settle <= cls_pkg::SETTLE_RST;
      cfg.t_maxblk <= cls_pkg::MAXBLK_RST;
      cfg.inrush_thr <= cls_pkg::INRUSH_RST;
    end else if (ce && wr_fire) begin
      case (aw_addr)
        cls_pkg::ADDR_CTRL: begin
          if (w_strb[0]) begin
            cfg.en <= w_data[cls_pkg::CTRL_EN_BIT];
            cfg.mode <= w_data[cls_pkg::CTRL_MODE_LSB +: 2];
            cfg.sw_block <= w_data[cls_pkg::CTRL_SWBLK_BIT];
          end
        end
        cls_pkg::ADDR_LOADOFF: cfg.t_loadoff <= TW'(merge(32'(cfg.t_loadoff), w_data, w_strb));
        cls_pkg::ADDR_SETTLE: cfg.t_settle <= TW'(merge(32'(cfg.t_settle), w_data, w_strb));
        cls_pkg::ADDR_MAXBLK: cfg.t_maxblk <= TW'(merge(32'(cfg.t_maxblk), w_data, w_strb));
        cls_pkg::ADDR_INRUSH: cfg.inrush_thr <= CW'(merge(32'(cfg.inrush_thr), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // AXI4-Lite read path: data one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    case (s_axi_araddr)
      cls_pkg::ADDR_CTRL: rd_word = 32'({cfg.sw_block, cfg.mode, cfg.en});
      cls_pkg::ADDR_LOADOFF: rd_word = 32'(cfg.t_loadoff);
      cls_pkg::ADDR_SETTLE: rd_word = 32'(cfg.t_settle);
      cls_pkg::ADDR_MAXBLK: rd_word = 32'(cfg.t_maxblk);
      cls_pkg::ADDR_INRUSH: rd_word = 32'(cfg.inrush_thr);
      cls_pkg::ADDR_STATUS: rd_word = status_word;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cls_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? cls_pkg::RESP_OKAY : cls_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Common timebase for all duration timers
  always_ff @(posedge clk) begin
    if (srst) begin
      presc <= '0;
    end else if (ce) begin
      presc <= tick ? 16'h0000 : presc + 16'h0001;
    end
  end
  assign tick = (presc == 16'(TICK_CYCLES - 1));

  // Detection and inrush comparisons
  assign cold = cold_detect(cfg.mode, !ins.breaker_position, ins.undercurrent);
  assign blocked = ins.ext_block || cfg.sw_block || !cfg.en || ins.autoreclose_running;
  assign cur_scaled = (CW+4)'(load_current) * (CW+4)'(cls_pkg::DROP_DEN);
  assign thr_scaled = (CW+4)'(cfg.inrush_thr) * (CW+4)'(cls_pkg::DROP_NUM);
  assign above_thr = load_current > cfg.inrush_thr;
  assign below_drop = cur_scaled <= thr_scaled;

  always_ff @(posedge clk) begin
    if (srst) begin
      inrush <= 1'b0;
    end else if (ce) begin
      if (state != cls_pkg::ST_RELEASE || next_state != cls_pkg::ST_RELEASE) begin
        inrush <= 1'b0;
      end else if (above_thr) begin
        inrush <= 1'b1;
      end else if (below_drop) begin
        inrush <= 1'b0;
      end
    end
  end

  assign st_run = (state == cls_pkg::ST_RELEASE) && !inrush && below_drop;

  cls_timer #(.TW(TW)) u_loadoff (
    .clk(clk), .srst(srst), .ce(ce),
    .run(state == cls_pkg::ST_LOADOFF),
    .tick(tick), .limit(cfg.t_loadoff), .done(lo_done)
  );

  cls_timer #(.TW(TW)) u_settle (
    .clk(clk), .srst(srst), .ce(ce),
    .run(st_run), .tick(tick), .limit(cfg.t_settle), .done(st_done)
  );

  cls_timer #(.TW(TW)) u_maxblk (
    .clk(clk), .srst(srst), .ce(ce),
    .run(state == cls_pkg::ST_RELEASE),
    .tick(tick), .limit(cfg.t_maxblk), .done(mb_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      cls_pkg::ST_WARM: if (cold) next_state = cls_pkg::ST_LOADOFF;
      cls_pkg::ST_LOADOFF: begin
        if (!cold) next_state = cls_pkg::ST_WARM;
        else if (lo_done) next_state = cls_pkg::ST_COLD;
      end
      cls_pkg::ST_COLD: if (!cold) next_state = cls_pkg::ST_RELEASE;
      cls_pkg::ST_RELEASE: begin
        if (cold) next_state = cls_pkg::ST_COLD;
        else if (st_done || mb_done) next_state = cls_pkg::ST_WARM;
      end
      default: next_state = cls_pkg::ST_WARM;
    endcase
    if (blocked) next_state = cls_pkg::ST_WARM;
  end

  // Output is a status level only; nothing here trips a breaker
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= cls_pkg::ST_WARM;
      cold_load_active <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cold_load_active <= (next_state == cls_pkg::ST_COLD) ||
        (next_state == cls_pkg::ST_RELEASE);
    end
  end

  assign status_word = 32'({cold, below_drop, inrush, state, cold_load_active});

  chk_reset_clear: assert property (@(posedge clk) srst |=> !cold_load_active && state == cls_pkg::ST_WARM)
    else $error("reset left the output or state set");

  chk_block_off: assert property (@(posedge clk) disable iff (srst)
    (ce && blocked) |=> !cold_load_active && state == cls_pkg::ST_WARM)
    else $error("blocked function still active");

  chk_mode_detect: assert property (@(posedge clk) disable iff (srst)
    (cfg.mode == cls_pkg::MODE_AND) |-> cold == (!ins.breaker_position && ins.undercurrent))
    else $error("and mode detection wrong");

  chk_loadoff_start: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_WARM && cold && !blocked) |=> state == cls_pkg::ST_LOADOFF && !cold_load_active)
    else $error("load-off timer not started");

  chk_active_raise: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_LOADOFF && lo_done && cold && !blocked) |=> cold_load_active)
    else $error("active not raised after load-off");

  chk_release_start: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_COLD && !cold && !blocked) |=> state == cls_pkg::ST_RELEASE && cold_load_active)
    else $error("inrush detection not started");

  chk_inrush_set: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_RELEASE && above_thr && next_state == cls_pkg::ST_RELEASE) |=> inrush)
    else $error("inrush not declared");

  chk_inrush_end: assert property (@(posedge clk) disable iff (srst)
    (ce && inrush && !above_thr && below_drop) |=> !inrush)
    else $error("inrush not ended at drop level");

  chk_settle_hold: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_RELEASE && !st_done && !mb_done && !blocked) |=> cold_load_active)
    else $error("released before settle expiry");

  chk_maxblk_end: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_RELEASE && mb_done && !cold) |=> !cold_load_active)
    else $error("max-block expiry did not release");

  // Settle expiry ends the release and with it the max-block count
  chk_maxblk_stop: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_RELEASE && st_done && !cold && !blocked) |=> state == cls_pkg::ST_WARM && !mb_done)
    else $error("max-block timer not stopped after settle");

  chk_settle_release: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_RELEASE && st_done && !mb_done && !cold && !blocked) |=> !cold_load_active)
    else $error("settle expiry did not release");

  chk_loadoff_abort: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_LOADOFF && !cold && !blocked) |=> state == cls_pkg::ST_WARM && !cold_load_active)
    else $error("load-off not abandoned when cold ended");

  chk_loadoff_hold: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_LOADOFF && !lo_done) |=> !cold_load_active)
    else $error("active raised before load-off expiry");

  chk_warm_quiet: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_WARM) |=> !cold_load_active)
    else $error("active raised without load-off delay");

  chk_cold_return: assert property (@(posedge clk) disable iff (srst)
    (ce && state == cls_pkg::ST_RELEASE && cold && !blocked) |=> state == cls_pkg::ST_COLD && cold_load_active)
    else $error("cold during release not followed");

  chk_tick_period: assert property (@(posedge clk) disable iff (srst)
    ce |-> presc <= 16'(TICK_CYCLES - 1))
    else $error("timebase prescaler out of range");
endmodule // cls_supervisor
`default_nettype wire

/* File: hw/cls_pkg.sv */
// Purpose: constants and types of the cold load supervisor
// Assumes: 50 MHz clock, 32-bit AXI4-Lite register bus
// Notes: overview of operation follows
// Overview of operation
// - Four cold detection modes: breaker, undercurrent, and, or
// - Warm-to-cold transition starts the load-off timer
// - Load-off expiry raises cold load active
// - Cold end starts the inrush detector
// - Current above threshold declares inrush
// - Inrush ends at ninety percent of threshold
// - Release through inrush path after settle timer
// - Max-block timer ends active even during inrush
// - Below 0.9 threshold for settle time stops max-block
// - Blocking input suppresses the whole function
// - Running auto-reclose blocks the function
// - Status signal only, never a trip
package cls_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int TW = 16;
  localparam int CW = 16;
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_LOADOFF = 8'h04;
  localparam logic [AW-1:0] ADDR_SETTLE = 8'h08;
  localparam logic [AW-1:0] ADDR_MAXBLK = 8'h0c;
  localparam logic [AW-1:0] ADDR_INRUSH = 8'h10;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_SWBLK_BIT = 3;
  localparam logic [1:0] MODE_BRK = 2'h0;
  localparam logic [1:0] MODE_UC = 2'h1;
  localparam logic [1:0] MODE_AND = 2'h2;
  localparam logic [1:0] MODE_OR = 2'h3;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] CTRL_MODE_RST = MODE_BRK;
  localparam logic [TW-1:0] LOADOFF_RST = 16'h0064;
  localparam logic [TW-1:0] SETTLE_RST = 16'h0032;
  localparam logic [TW-1:0] MAXBLK_RST = 16'h01f4;
  localparam logic [CW-1:0] INRUSH_RST = 16'h0200;
  localparam logic [3:0] DROP_NUM = 4'h9;
  localparam logic [3:0] DROP_DEN = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_WARM, ST_LOADOFF, ST_COLD, ST_RELEASE} cls_state_t;

  typedef struct packed {
    logic en;
    logic [1:0] mode;
    logic sw_block;
    logic [TW-1:0] t_loadoff;
    logic [TW-1:0] t_settle;
    logic [TW-1:0] t_maxblk;
    logic [CW-1:0] inrush_thr;
  } cls_cfg_t;

  typedef struct packed {
    logic breaker_position;
    logic undercurrent;
    logic ext_block;
    logic autoreclose_running;
  } cls_ins_t;
endpackage

/* File: hw/cls_timer.sv */
// Purpose: tick-based duration timer
// Assumes: run low clears the count
// Notes: done is high while run and the count reached the limit
`timescale 1ns/1ps
`default_nettype none
module cls_timer #(
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic [TW-1:0] limit,
  output logic done
);
  logic [TW-1:0] count;

  if (TW < 2) begin : g_bad_width
    $error("cls_timer: TW too small");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else if (ce) begin
      if (!run) begin
        count <= '0;
      end else if (tick && (count < limit)) begin
        count <= count + 1'b1;
      end
    end
  end

  assign done = run && (count >= limit);
endmodule // cls_timer
`default_nettype wire

/* File: tb/cls_plant.sv */
// Purpose: far-side model: breaker, current transformer, undercurrent relay, blocking sources
// Assumes: breaker and current follow the bench's commands one clock later
// Notes: leak lets a scenario show current through an open breaker
`timescale 1ns/1ps
`default_nettype none
module cls_plant #(
  parameter logic [15:0] UC_LEVEL = 16'h0040
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic close_cmd,
  input wire logic [15:0] demand,
  input wire logic [15:0] leak,
  input wire logic block_cmd,
  input wire logic ar_cmd,
  output var cls_pkg::cls_ins_t ins,
  output logic [15:0] load_current
);
  logic closed;
  always_ff @(posedge clk) begin
    if (srst) begin
      closed <= 1'b1;
      load_current <= 16'h0000;
    end else begin
      closed <= close_cmd;
      load_current <= close_cmd ? demand : leak;
    end
  end
  // Undercurrent is the comparator of the current measurement
  assign ins = '{breaker_position: closed, undercurrent: (load_current < UC_LEVEL),
    ext_block: block_cmd, autoreclose_running: ar_cmd};
endmodule // cls_plant
`default_nettype wire

/* File: tb/cls_supervisor_bench.sv */
// Purpose: self-checking bench of the cold load supervisor
// Assumes: tick of 4 clocks; registers reached over AXI4-Lite
// Notes: timers shortened so every path finishes in a few hundred cycles
`timescale 1ns/1ps
`default_nettype none
module cls_supervisor_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic close_cmd = 1'b1;
  logic block_cmd = 1'b0;
  logic ar_cmd = 1'b0;
  logic [15:0] demand = 16'h0080;
  logic [15:0] leak = 16'h0000;
  cls_pkg::cls_ins_t ins;
  logic [15:0] load_current;
  logic active;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  cls_plant plant (.clk(clk), .srst(srst), .close_cmd(close_cmd), .demand(demand), .leak(leak),
    .block_cmd(block_cmd), .ar_cmd(ar_cmd), .ins(ins), .load_current(load_current));

  cls_supervisor #(.TICK_CYCLES(4)) dut (.clk(clk), .srst(srst), .ce(1'b1), .ins(ins),
    .load_current(load_current), .cold_load_active(active),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    chk(what, rd & mask, exp);
  endtask

  // Stay: active must hold v for n cycles; otherwise it must reach v within n cycles
  task watch(input logic v, input int n, input bit stay, input string what);
    bit ok;
    ok = stay;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (stay && active !== v) ok = 1'b0;
      if (!stay && active === v) begin
        ok = 1'b1;
        break;
      end
    end
    chk(what, ok, 1'b1);
  endtask

  initial begin
    bit brk, uc, e;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk(cls_pkg::ADDR_CTRL, 32'hffffffff, {29'h0, cls_pkg::CTRL_MODE_RST, cls_pkg::CTRL_EN_RST}, "ctrl");
    rchk(cls_pkg::ADDR_LOADOFF, 32'hffffffff, {16'h0000, cls_pkg::LOADOFF_RST}, "loadoff");
    rchk(cls_pkg::ADDR_SETTLE, 32'hffffffff, {16'h0000, cls_pkg::SETTLE_RST}, "settle");
    rchk(cls_pkg::ADDR_MAXBLK, 32'hffffffff, {16'h0000, cls_pkg::MAXBLK_RST}, "maxblk");
    rchk(cls_pkg::ADDR_INRUSH, 32'hffffffff, {16'h0000, cls_pkg::INRUSH_RST}, "inrush thr");
    rchk(cls_pkg::ADDR_STATUS, 32'h00000007, 32'h00000000, "status after reset");
    rchk(8'h18, 32'hffffffff, 32'h00000000, "unmapped data");
    chk("unmapped resp", rs, cls_pkg::RESP_SLVERR);
    wr(cls_pkg::ADDR_LOADOFF, 32'h00000002);
    wr(cls_pkg::ADDR_SETTLE, 32'h00000003);
    wr(cls_pkg::ADDR_MAXBLK, 32'h00000028);
    wr(cls_pkg::ADDR_INRUSH, 32'h00000100);
    chk("write resp", rs, cls_pkg::RESP_OKAY);
    wr(8'h18, 32'h0000ffff);
    chk("unmapped write resp", rs, cls_pkg::RESP_SLVERR);
    rchk(cls_pkg::ADDR_INRUSH, 32'hffffffff, 32'h00000100, "inrush thr written");
    // Plant states: closed loaded, closed light, open dead, open with leakage current
    for (int m = 0; m < 4; m++) begin
      wr(cls_pkg::ADDR_CTRL, {29'h0, m[1:0], 1'b1});
      for (int s = 0; s < 4; s++) begin
        close_cmd <= (s < 2);
        demand <= (s == 1) ? 16'h0010 : 16'h0080;
        leak <= (s == 3) ? 16'h0080 : 16'h0000;
        repeat (3) @(posedge clk);
        brk = (s >= 2);
        uc = (s == 1 || s == 2);
        e = (m == 0) ? brk : (m == 1) ? uc : (m == 2) ? (brk && uc) : (brk || uc);
        rchk(cls_pkg::ADDR_STATUS, 32'h00000020, {26'h0, e, 5'h00}, "cold detect");
      end
    end
    wr(cls_pkg::ADDR_CTRL, 32'h00000001);
    close_cmd <= 1'b1;
    demand <= 16'h0080;
    leak <= 16'h0000;
    watch(1'b0, 200, 1'b0, "back to warm");
    close_cmd <= 1'b0;
    watch(1'b0, 5, 1'b1, "load-off delay");
    watch(1'b1, 40, 1'b0, "active after load-off");
    close_cmd <= 1'b1;
    demand <= 16'h0200;
    repeat (4) @(posedge clk);
    rchk(cls_pkg::ADDR_STATUS, 32'h0000000f, 32'h0000000f, "release with inrush");
    watch(1'b1, 24, 1'b1, "held during inrush");
    demand <= 16'h00e7;
    repeat (4) @(posedge clk);
    rchk(cls_pkg::ADDR_STATUS, 32'h00000008, 32'h00000008, "inrush above 90 percent");
    demand <= 16'h00e6;
    watch(1'b1, 8, 1'b1, "settle delay");
    watch(1'b0, 24, 1'b0, "released by settle");
    demand <= 16'h0080;
    close_cmd <= 1'b0;
    watch(1'b1, 40, 1'b0, "active again");
    close_cmd <= 1'b1;
    demand <= 16'h0200;
    watch(1'b1, 120, 1'b1, "held by max-block");
    watch(1'b0, 60, 1'b0, "max-block expiry");
    demand <= 16'h0080;
    for (int k = 0; k < 4; k++) begin
      close_cmd <= 1'b0;
      watch(1'b1, 40, 1'b0, "active before block");
      case (k)
        0: block_cmd <= 1'b1;
        1: ar_cmd <= 1'b1;
        2: wr(cls_pkg::ADDR_CTRL, 32'h00000009);
        default: wr(cls_pkg::ADDR_CTRL, 32'h00000000);
      endcase
      watch(1'b0, 4, 1'b0, "block clears active");
      watch(1'b0, 30, 1'b1, "blocked stays off");
      close_cmd <= 1'b1;
      repeat (2) @(posedge clk);
      block_cmd <= 1'b0;
      ar_cmd <= 1'b0;
      wr(cls_pkg::ADDR_CTRL, 32'h00000001);
    end
    close_cmd <= 1'b0;
    watch(1'b1, 40, 1'b0, "active before reset");
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("active after reset", active, 1'b0);
    rchk(cls_pkg::ADDR_LOADOFF, 32'hffffffff, {16'h0000, cls_pkg::LOADOFF_RST}, "loadoff after reset");
    complete_run();
  end
endmodule // cls_supervisor_bench
`default_nettype wire
